// ---- inc/pti_consts.svh ----
`ifndef PTI_CONSTS_SVH
`define PTI_CONSTS_SVH
// controller clock and timebase
`define PTI_CLK_HZ 25000000
`define PTI_TICK_MS 10
`define PTI_TICK_CYC ((`PTI_CLK_HZ / 1000) * `PTI_TICK_MS)
// setpoint in 10 ms units: 1..255 gives 10..2550 ms, zero disables
`define PTI_SP_W 8
`define PTI_SP_OFF 8'h00
`define PTI_SP_RST 8'h00
// enable bit reset value
`define PTI_EN_RST 1'b1
// subroutine call stack depth
`define PTI_STACK_DEPTH 3
`endif

// ---- inc/pti_pkg.sv ----
package pti_pkg;
    typedef enum logic [1:0] {
        PTI_SCAN,
        PTI_ENTER,
        PTI_RUN,
        PTI_EXIT
    } pti_state_t;
endpackage : pti_pkg

// ---- core/pti_periodic_timed_interrupt.sv ----
// Decided for this implementation: strobed register access and the register addresses.
`include "pti_consts.svh"
`default_nettype none

module pti_periodic_timed_interrupt #(
    parameter int TICK_CYC = `PTI_TICK_CYC,
    parameter int SP_W = `PTI_SP_W
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [7:0] addr,
    input wire logic [SP_W-1:0] wrData,
    input wire logic wrStb,
    input wire logic rdStb,
    output logic [SP_W-1:0] rdData,
    input wire logic remoteRunMode,
    input wire logic remoteTestMode,
    input wire logic timedInterruptDisable,
    input wire logic timedInterruptEnable,
    input wire logic timedStartSetpoint,
    input wire logic [SP_W-1:0] startSetpoint,
    input wire logic userFaultActive,
    input wire logic counterIntActive,
    input wire logic noDisturbZone,
    input wire logic routineDone,
    input wire logic subroutineCall,
    input wire logic subroutineReturn,
    input wire logic [15:0] arithFlagsIn,
    input wire logic [15:0] mathLoIn,
    input wire logic [15:0] mathHiIn,
    input wire logic [15:0] indexIn,
    output logic scanSuspend,
    output logic routineStart,
    output logic restoreStb,
    output logic [15:0] arithFlagsOut,
    output logic [15:0] mathLoOut,
    output logic [15:0] mathHiOut,
    output logic [15:0] indexOut,
    output logic intEnable,
    output logic pendingFlag,
    output logic lostFlag,
    output logic minorError,
    output logic callOverflow
);
    localparam int TW = $clog2(TICK_CYC + 1);

    typedef struct packed {
        pti_pkg::pti_state_t st;
        logic [TW-1:0] tickCnt;
        logic [SP_W-1:0] setpoint;
        logic [SP_W-1:0] elapsed;
        logic running;
        logic en;
        logic pend;
        logic lost;
        logic minErr;
        logic callOvf;
        logic [1:0] depth;
        logic susp;
        logic startP;
        logic restP;
        logic [15:0] svFlags;
        logic [15:0] svMathLo;
        logic [15:0] svMathHi;
        logic [15:0] svIndex;
        logic [SP_W-1:0] rd;
    } pti_state_reg_t;

    pti_state_reg_t s_reg;
    pti_state_reg_t s_next;
    logic tick;
    logic expire;
    logic busy;
    logic higherBusy;

    always_comb begin
        s_next = s_reg;
        s_next.startP = 1'b0;
        s_next.restP = 1'b0;
        tick = 1'b0;
        expire = 1'b0;
        busy = (s_reg.st != pti_pkg::PTI_SCAN);
        higherBusy = userFaultActive | counterIntActive;
        // timer runs once the controller is in a running mode
        if (remoteRunMode | remoteTestMode) begin
            s_next.running = 1'b1;
        end
        if (s_reg.running) begin
            // prescaler to a 10 ms tick keeps the compare narrow
            if (s_reg.tickCnt == TW'(TICK_CYC - 1)) begin
                s_next.tickCnt = '0;
                tick = 1'b1;
            end else begin
                s_next.tickCnt = s_reg.tickCnt + 1'b1;
            end
        end
        if (tick && s_reg.setpoint != '0) begin
            if (s_reg.elapsed + 1'b1 >= s_reg.setpoint) begin
                expire = 1'b1;
                s_next.elapsed = '0;
            end else begin
                s_next.elapsed = s_reg.elapsed + 1'b1;
            end
        end
        if (expire) begin
            if (s_reg.pend) begin
                s_next.lost = 1'b1;
            end else if (busy || !s_reg.en) begin
                s_next.pend = 1'b1;
            end
            if (busy) begin
                s_next.minErr = 1'b1;
            end
        end
        // rung-level instructions; disable wins if both are true
        if (timedInterruptEnable) begin
            s_next.en = 1'b1;
        end
        if (timedStartSetpoint) begin
            s_next.setpoint = startSetpoint;
            s_next.elapsed = '0;
            s_next.tickCnt = '0;
            s_next.en = 1'b1;
        end
        if (timedInterruptDisable) begin
            s_next.en = 1'b0;
        end
        // software write to the setpoint word
        if (wrStb && addr == `PTI_SP_OFF) begin
            s_next.setpoint = wrData;
        end
        s_next.rd = '0;
        if (rdStb && addr == `PTI_SP_OFF) begin
            s_next.rd = s_reg.setpoint;
        end
        case (s_reg.st)
            pti_pkg::PTI_SCAN: begin
                s_next.susp = 1'b0;
                // expiry with enable set and nothing pending runs now
                if ((expire && s_reg.en && !s_reg.pend) ||
                    (s_reg.pend && s_reg.en)) begin
                    if (!expire && s_reg.pend) begin
                        s_next.pend = 1'b0;
                    end
                    s_next.st = pti_pkg::PTI_ENTER;
                end
            end
            pti_pkg::PTI_ENTER: begin
                // wait out protected operations and higher sources
                if (!noDisturbZone && !higherBusy) begin
                    s_next.susp = 1'b1;
                    s_next.startP = 1'b1;
                    s_next.depth = '0;
                    s_next.svFlags = arithFlagsIn;
                    s_next.svMathLo = mathLoIn;
                    s_next.svMathHi = mathHiIn;
                    s_next.svIndex = indexIn;
                    s_next.st = pti_pkg::PTI_RUN;
                end
            end
            pti_pkg::PTI_RUN: begin
                if (subroutineCall) begin
                    if (s_reg.depth == 2'(`PTI_STACK_DEPTH)) begin
                        s_next.callOvf = 1'b1;
                    end else begin
                        s_next.depth = s_reg.depth + 1'b1;
                    end
                end else if (subroutineReturn && s_reg.depth != '0) begin
                    s_next.depth = s_reg.depth - 1'b1;
                end
                if (routineDone) begin
                    s_next.restP = 1'b1;
                    s_next.st = pti_pkg::PTI_EXIT;
                end
            end
            pti_pkg::PTI_EXIT: begin
                if (s_reg.pend && s_reg.en && !expire) begin
                    s_next.pend = 1'b0;
                    s_next.startP = 1'b1;
                    s_next.svFlags = arithFlagsIn;
                    s_next.svMathLo = mathLoIn;
                    s_next.svMathHi = mathHiIn;
                    s_next.svIndex = indexIn;
                    s_next.depth = '0;
                    s_next.st = pti_pkg::PTI_RUN;
                end else begin
                    s_next.susp = 1'b0;
                    s_next.st = pti_pkg::PTI_SCAN;
                end
            end
            default: begin
                s_next.st = pti_pkg::PTI_SCAN;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            s_reg <= '0;
            s_reg.st <= pti_pkg::PTI_SCAN;
            s_reg.setpoint <= `PTI_SP_RST;
            s_reg.en <= `PTI_EN_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    assign rdData = s_reg.rd;
    assign scanSuspend = s_reg.susp;
    assign routineStart = s_reg.startP;
    assign restoreStb = s_reg.restP;
    assign arithFlagsOut = s_reg.svFlags;
    assign mathLoOut = s_reg.svMathLo;
    assign mathHiOut = s_reg.svMathHi;
    assign indexOut = s_reg.svIndex;
    assign intEnable = s_reg.en;
    assign pendingFlag = s_reg.pend;
    assign lostFlag = s_reg.lost;
    assign minorError = s_reg.minErr;
    assign callOverflow = s_reg.callOvf;

    // exit and entry steps shared by the handshake checks
    sequence s_started;
        routineStart && scanSuspend;
    endsequence
    sequence s_rerun_step;
        routineStart && scanSuspend && !restoreStb;
    endsequence
    sequence s_resume_step;
        !scanSuspend && !routineStart;
    endsequence
    // words are taken in the cycle that opens the routine, never later
    sequence s_words_saved;
        arithFlagsOut == $past(arithFlagsIn)
        && mathLoOut == $past(mathLoIn)
        && mathHiOut == $past(mathHiIn)
        && indexOut == $past(indexIn);
    endsequence
    sequence s_words_kept;
        $stable(arithFlagsOut) && $stable(mathLoOut)
        && $stable(mathHiOut) && $stable(indexOut);
    endsequence

    a_zero_no_start: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (s_reg.setpoint == '0 && s_reg.st == pti_pkg::PTI_SCAN
         && !s_reg.pend) |=> s_reg.st == pti_pkg::PTI_SCAN)
        else $error("start with zero setpoint");
    a_disable_holds: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        timedInterruptDisable |=> !intEnable)
        else $error("enable bit not cleared");
    a_enable_sets: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (timedInterruptEnable && !timedInterruptDisable) |=> intEnable)
        else $error("enable bit not set");
    a_lost_on_pend: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (expire && s_reg.pend) |=> lostFlag)
        else $error("lost flag missed");
    a_pend_on_busy: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (expire && s_reg.st != pti_pkg::PTI_SCAN) |=> pendingFlag)
        else $error("pending flag missed");
    a_prio_defer: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (s_reg.st == pti_pkg::PTI_ENTER && (userFaultActive
         || counterIntActive || noDisturbZone)) |=> !routineStart)
        else $error("started under higher priority");
    a_restore_done: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (s_reg.st == pti_pkg::PTI_RUN && routineDone) |=> restoreStb
        ##1 (routineStart || !scanSuspend))
        else $error("exit sequence wrong");
    a_depth_bound: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        s_reg.depth <= 2'(`PTI_STACK_DEPTH))
        else $error("call depth overrun");
    a_start_restart: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (timedStartSetpoint && !timedInterruptDisable)
        |=> (s_reg.elapsed == '0 && intEnable))
        else $error("start did not restart timer");
    a_err_overrun: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (expire && s_reg.st != pti_pkg::PTI_SCAN) |=> minorError)
        else $error("overrun not flagged");
    a_rerun_pending: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (s_reg.st == pti_pkg::PTI_EXIT && s_reg.pend && s_reg.en
         && !expire) |=> s_rerun_step)
        else $error("pending rerun missed");
    a_resume_scan: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (s_reg.st == pti_pkg::PTI_EXIT && !(s_reg.pend && s_reg.en
         && !expire)) |=> s_resume_step)
        else $error("scan not resumed");
    a_pend_clear: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (s_reg.st == pti_pkg::PTI_EXIT && s_reg.pend && s_reg.en
         && !expire) |=> !pendingFlag)
        else $error("pending flag not cleared on rerun");
    a_entry_save: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (s_reg.st == pti_pkg::PTI_ENTER && !noDisturbZone && !higherBusy)
        |=> s_started ##0 s_words_saved)
        else $error("entry did not save words");
    a_save_hold: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (s_reg.st == pti_pkg::PTI_RUN) |=> s_words_kept)
        else $error("saved words changed in routine");
    a_timer_free: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (s_reg.running && !intEnable && !timedStartSetpoint
         && s_reg.tickCnt != TW'(TICK_CYC - 1))
        |=> s_reg.tickCnt == TW'($past(s_reg.tickCnt) + 1'b1))
        else $error("timer stalled while disabled");
    a_run_start: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (remoteRunMode || remoteTestMode) |=> s_reg.running)
        else $error("timer not started");
    a_running_latch: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        s_reg.running |=> s_reg.running)
        else $error("timer stopped");
    a_expire_restart: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        expire |=> s_reg.elapsed == '0)
        else $error("interval not restarted");
    a_enable_keeps: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (timedInterruptEnable && !timedStartSetpoint && !wrStb)
        |=> s_reg.setpoint == $past(s_reg.setpoint))
        else $error("enable changed the setpoint");
    a_disabled_pend: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (expire && !s_reg.en && !s_reg.pend) |=> pendingFlag)
        else $error("disabled expiry not recorded");
    a_no_start_disabled: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (s_reg.st == pti_pkg::PTI_SCAN && !s_reg.en)
        |=> s_reg.st == pti_pkg::PTI_SCAN)
        else $error("entry while disabled");
    a_sp_write: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (wrStb && addr == `PTI_SP_OFF)
        |=> s_reg.setpoint == $past(wrData))
        else $error("setpoint write lost");
    a_read_stands: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (rdStb && addr == `PTI_SP_OFF)
        |=> rdData == $past(s_reg.setpoint))
        else $error("setpoint read wrong");
    a_read_idle: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        !rdStb |=> rdData == '0)
        else $error("read data not idle");
    a_overflow_call: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (s_reg.st == pti_pkg::PTI_RUN && subroutineCall
         && s_reg.depth == 2'(`PTI_STACK_DEPTH)) |=> callOverflow)
        else $error("call overflow not flagged");
    a_depth_reset: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        routineStart |-> s_reg.depth == '0)
        else $error("call depth not cleared at start");
    a_suspend_run: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (s_reg.st == pti_pkg::PTI_RUN) |-> scanSuspend)
        else $error("scan not suspended in routine");
endmodule : pti_periodic_timed_interrupt
`default_nettype wire

// ---- verification/pti_scan_model.sv ----
`default_nettype none
module pti_scan_model (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic routineStart,
    input wire logic [7:0] runLen,
    input wire logic enReq,
    output logic routineDone = 1'b0,
    output logic enPulse = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] left = 8'h00;
    logic first = 1'b1;
    // a short runLen keeps the routine inside the interval
    always @(posedge ref_clk) begin
        routineDone <= left == 8'h01;
        enPulse <= enReq | (first & ~sys_rst);
        first <= sys_rst;
        if (sys_rst) begin
            left <= 8'h00;
        end else if (routineStart) begin
            left <= runLen;
        end else if (left != 8'h00) begin
            left <= left - 8'h01;
        end
    end
endmodule : pti_scan_model
`default_nettype wire

// ---- verification/tb.sv ----
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, rst = 1'b1, wS = 1'b0, rS = 1'b0, run = 1'b0;
    logic tst = 1'b0, dis = 1'b0, enReq = 1'b0, sts = 1'b0, flt = 1'b0;
    logic hsc = 1'b0, zone = 1'b0, call = 1'b0, ret = 1'b0;
    logic done, en, susp, go, rest, ien, pend, lost, merr, ovf;
    logic [7:0] adr = 8'h00, wd = 8'h00, rdD, stsV = 8'h00, len = 8'h02;
    logic [15:0] sw = 16'h0000, o0, o1, o2, o3;
    int nMismatch = 0, checkCount = 0, cyc = 0, hits;
    always #20 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    pti_periodic_timed_interrupt #(.TICK_CYC(4)) DUT (
        .ref_clk(clk), .sys_rst(rst), .addr(adr), .wrData(wd),
        .wrStb(wS), .rdStb(rS), .rdData(rdD), .remoteRunMode(run),
        .remoteTestMode(tst), .timedInterruptDisable(dis),
        .timedInterruptEnable(en), .timedStartSetpoint(sts),
        .startSetpoint(stsV), .userFaultActive(flt),
        .counterIntActive(hsc), .noDisturbZone(zone),
        .routineDone(done), .subroutineCall(call),
        .subroutineReturn(ret), .arithFlagsIn(sw),
        .mathLoIn(sw + 16'h0001), .mathHiIn({sw[7:0], sw[15:8]}),
        .indexIn(~sw), .scanSuspend(susp),
        .routineStart(go), .restoreStb(rest), .arithFlagsOut(o0),
        .mathLoOut(o1), .mathHiOut(o2), .indexOut(o3), .intEnable(ien),
        .pendingFlag(pend), .lostFlag(lost), .minorError(merr),
        .callOverflow(ovf));
    pti_scan_model PM (.ref_clk(clk), .sys_rst(rst), .routineStart(go),
        .runLen(len), .enReq(enReq), .routineDone(done), .enPulse(en));
    task automatic final_report;
        if (nMismatch == 0 && checkCount > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : final_report
    task automatic check(input logic [15:0] s, e);
        checkCount++;
        if (s !== e) begin
            nMismatch++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, d);
        @(posedge clk);
        adr <= a;
        wd <= d;
        wS <= 1'b1;
        @(posedge clk);
        wS <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, e);
        @(posedge clk);
        adr <= a;
        rS <= 1'b1;
        @(posedge clk);
        rS <= 1'b0;
        #1;
        check({8'h00, rdD}, {8'h00, e});
    endtask : rd
    function automatic logic pick(input int s);
        return s == 0 ? go : s == 1 ? rest : s == 2 ? pend : lost;
    endfunction : pick
    // bounded: a hang ends the run instead of stalling it
    task automatic waitFor(input int s, input int lim);
        int i;
        i = 0;
        do begin
            @(posedge clk);
            #1;
            i++;
            if (i > lim) begin
                nMismatch++;
                final_report();
            end
        end while (pick(s) !== 1'b1);
    endtask : waitFor
    task automatic quiet(input int n);
        hits = 0;
        repeat (n) begin
            @(posedge clk);
            #1;
            if (go === 1'b1) hits++;
        end
    endtask : quiet
    task automatic rstDut;
        @(posedge clk);
        rst <= 1'b1;
        run <= 1'b0;
        tst <= 1'b0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
    endtask : rstDut
    task automatic sReset;
        rstDut();
        #1;
        check(ien, 1'b1);
        rd(8'h00, 8'h00);
        @(posedge clk);
        run <= 1'b1;
        quiet(40);
        check(16'(hits), 16'd0);
        @(posedge clk);
        stsV <= 8'h02;
        sts <= 1'b1;
        @(posedge clk);
        sts <= 1'b0;
        rd(8'h00, 8'h02);
        waitFor(0, 12);
    endtask : sReset
    task automatic sBasic;
        int t0;
        rstDut();
        wr(8'h00, 8'hFF);
        rd(8'h00, 8'hFF);
        wr(8'h00, 8'h02);
        wr(8'h07, 8'h55);
        rd(8'h00, 8'h02);
        rd(8'h07, 8'h00);
        @(posedge clk);
        sw <= 16'hA5C3;
        run <= 1'b1;
        waitFor(0, 20);
        t0 = cyc;
        check(susp, 1'b1);
        @(posedge clk);
        sw <= 16'h0F0F;
        waitFor(1, 12);
        check(o0, 16'hA5C3);
        check(o3, 16'h5A3C);
        check(o1, 16'hA5C4);
        check(o2, 16'hC3A5);
        @(posedge clk);
        #1;
        check(susp, 1'b0);
        waitFor(0, 12);
        check(16'(cyc - t0), 16'd8);
        check(o0, 16'h0F0F);
    endtask : sBasic
    task automatic sOverrun;
        rstDut();
        wr(8'h00, 8'h03);
        @(posedge clk);
        len <= 8'd25;
        tst <= 1'b1;
        waitFor(0, 30);
        waitFor(2, 16);
        check(lost, 1'b0);
        waitFor(3, 16);
        check(merr, 1'b1);
        @(posedge clk);
        len <= 8'd2;
        waitFor(0, 12);
        @(posedge clk);
        #1;
        check(pend, 1'b0);
    endtask : sOverrun
    task automatic sDisable;
        rstDut();
        wr(8'h00, 8'h02);
        @(posedge clk);
        dis <= 1'b1;
        run <= 1'b1;
        @(posedge clk);
        dis <= 1'b0;
        #1;
        check(ien, 1'b0);
        quiet(24);
        check(16'(hits), 16'd0);
        check(pend & lost, 1'b1);
        @(posedge clk);
        enReq <= 1'b1;
        @(posedge clk);
        enReq <= 1'b0;
        waitFor(0, 10);
        check(ien, 1'b1);
        rd(8'h00, 8'h02);
    endtask : sDisable
    task automatic sPrio;
        for (int k = 0; k < 3; k++) begin
            rstDut();
            wr(8'h00, 8'h02);
            @(posedge clk);
            flt <= k == 0;
            hsc <= k == 1;
            zone <= k == 2;
            run <= 1'b1;
            quiet(20);
            check(16'(hits), 16'd0);
            @(posedge clk);
            {flt, hsc, zone} <= 3'b000;
            waitFor(0, 4);
        end
    endtask : sPrio
    task automatic sCalls;
        rstDut();
        wr(8'h00, 8'h04);
        @(posedge clk);
        len <= 8'd40;
        run <= 1'b1;
        waitFor(0, 30);
        // three calls, one return, then two calls: only the last overflows
        for (int k = 0; k < 6; k++) begin
            @(posedge clk);
            call <= k != 3;
            ret <= k == 3;
            @(posedge clk);
            call <= 1'b0;
            ret <= 1'b0;
            #1;
            check(ovf, k == 5);
        end
    endtask : sCalls
    initial begin
        sReset();
        sBasic();
        sOverrun();
        sDisable();
        sPrio();
        sCalls();
        final_report();
    end
endmodule : tb
`default_nettype wire
